// ===== i2c_rx_pkg.sv
// Constants and types for the two-wire receive, acknowledge and stop sequencer.
// Assumes a single 125 MHz clock domain and an AXI4-Lite register port.
package i2c_rx_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] BUFFER_OFFSET = 4'h8;
  localparam logic [3:0] BAUD_OFFSET = 4'hC;
  // ==========================================================
  // Control register fields
  localparam int EN_POS = 0;
  localparam int RECEIVE_ENABLE_BIT_POS = 1;
  localparam int ACK_SEQUENCE_ENABLE_POS = 2;
  localparam int ACK_DATA_BIT_POS = 3;
  localparam int PEN_POS = 4;
  localparam int IE_POS = 5;
  // ==========================================================
  // Status register fields
  localparam int BF_POS = 0;
  localparam int OV_POS = 1;
  localparam int WRITE_COLLISION_FLAG_POS = 2;
  localparam int SIF_POS = 3;
  localparam int BCL_POS = 4;
  localparam int PDET_POS = 5;
  localparam int SDET_POS = 6;
  localparam int BUSY_POS = 7;
  // ==========================================================
  // Reset values and bus answers
  localparam logic [7:0] BAUD_RESET = 8'h09;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    IDLE, RX_CLOCK, ACK_LOW, ACK_WAIT, ACK_HIGH,
    STOP_SDA, STOP_CNT, STOP_SCLH, STOP_SDAH, STOP_END
  } seq_state_type;
endpackage

// ===== i2c_master_rx_ack_stop.sv
// Master-side two-wire receive, acknowledge and stop sequencer with AXI4-Lite registers.
// Assumes external pull-ups on both lines and pins that are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - A receive request written while the sequencer is busy is dropped.
// - While receiving, each baud tick toggles the clock; data is shifted in.
// - After the eighth falling edge: buffer loaded, flags set, clock held low.
// - Buffer-full sets on each received byte and clears on a buffer read.
// - A byte completing while buffer-full is still set raises overflow.
// - A buffer write during reception sets write-collision, buffer kept.
// - Acknowledge: clock low, data bit driven, one baud period, clock released.
// - Clock seen high, one baud period, clock low, acknowledge done, idle.
// - A buffer write during acknowledge sets write-collision, buffer kept.
// - Stop pulls data low; once seen low the baud count reloads.
// - On that timeout the clock is released, data one baud period later.
// - Data high with clock high sets stop-detected; a period later finish.
// - A buffer write during stop sets write-collision, buffer kept.
// - Reset disables the block and aborts any transfer.
// - Start and stop detected bits clear on reset or disable.
// - A bus stop seen after a start while idle raises the interrupt if enabled.
// - Sampled data is compared with what is driven; mismatch flags collision.
// - Arbitration is watched only in the acknowledge clock-high phase and the stop data-high phase.
// - A collision sets its flag and returns the sequencer to idle.
// - Every baud load takes the 8-bit reload value.
module i2c_master_rx_ack_stop
  import i2c_rx_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [3:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Bus lines
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  // Interrupt
  output logic irq
);
  // ==========================================================
  // State
  typedef struct packed {
    seq_state_type state;
    logic [7:0] cnt;
    logic run;
    logic [2:0] bits;
    logic [7:0] sreg;
    logic [7:0] buffer;
    logic [7:0] reload;
    logic en;
    logic ie;
    logic receive_enable_bit;
    logic ack_sequence_enable;
    logic ack_data_bit;
    logic stop_enable;
    logic bf;
    logic ov;
    logic write_collision_flag;
    logic sif;
    logic bcl;
    logic sdet;
    logic pdet;
    logic scl_rel;
    logic sda_rel;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic sda_prev;
    logic awready;
    logic wready;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic wstb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } regs_type;

  localparam regs_type RESET_REGS = '{
    state: IDLE, reload: BAUD_RESET, scl_rel: 1'b1, sda_rel: 1'b1,
    scl_sync: 2'h3, sda_sync: 2'h3, sda_prev: 1'b1,
    awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  regs_type r;
  regs_type next_r;
  logic tick;
  logic scl_s;
  logic sda_s;
  logic wr_fire;
  logic collide;
  logic [7:0] ctrl_v;
  logic [7:0] stat_v;

  // ==========================================================
  // Next-state logic
  always_comb begin
    next_r = r;
    tick = r.run && (r.cnt == BYTE_ZERO);
    scl_s = r.scl_sync[1];
    sda_s = r.sda_sync[1];
    wr_fire = 1'b0;
    collide = 1'b0;
    next_r.scl_sync = {r.scl_sync[0], scl_i};
    next_r.sda_sync = {r.sda_sync[0], sda_i};
    next_r.sda_prev = sda_s;
    ctrl_v = BYTE_ZERO;
    ctrl_v[EN_POS] = r.en;
    ctrl_v[RECEIVE_ENABLE_BIT_POS] = r.receive_enable_bit;
    ctrl_v[ACK_SEQUENCE_ENABLE_POS] = r.ack_sequence_enable;
    ctrl_v[ACK_DATA_BIT_POS] = r.ack_data_bit;
    ctrl_v[PEN_POS] = r.stop_enable;
    ctrl_v[IE_POS] = r.ie;
    stat_v = BYTE_ZERO;
    stat_v[BF_POS] = r.bf;
    stat_v[OV_POS] = r.ov;
    stat_v[WRITE_COLLISION_FLAG_POS] = r.write_collision_flag;
    stat_v[SIF_POS] = r.sif;
    stat_v[BCL_POS] = r.bcl;
    stat_v[PDET_POS] = r.pdet;
    stat_v[SDET_POS] = r.sdet;
    stat_v[BUSY_POS] = (r.state != IDLE);
    if (r.run) begin
      next_r.cnt = tick ? r.reload : r.cnt - 8'h01;
    end
    // Start and stop detection on the bus
    if (scl_s && r.sda_prev && !sda_s) begin
      next_r.sdet = 1'b1;
      next_r.pdet = 1'b0;
    end
    if (scl_s && !r.sda_prev && sda_s) begin
      next_r.pdet = 1'b1;
      next_r.sdet = 1'b0;
    end

    // ========================================================
    // AXI4-Lite slave: address and data taken in either order
    if (awvalid && r.awready) begin
      next_r.awaddr = awaddr;
      next_r.awready = 1'b0;
    end
    if (wvalid && r.wready) begin
      next_r.wdata = wdata;
      next_r.wstb = wstrb[0];
      next_r.wready = 1'b0;
    end
    if (!r.awready && !r.wready && !r.bvalid) begin
      wr_fire = 1'b1;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      case (r.awaddr)
        CTRL_OFFSET: if (r.wstb) begin
          next_r.en = r.wdata[EN_POS];
          next_r.ie = r.wdata[IE_POS];
          next_r.ack_data_bit = r.wdata[ACK_DATA_BIT_POS];
          if (r.state == IDLE && r.wdata[EN_POS] && r.en) begin
            next_r.receive_enable_bit = r.wdata[RECEIVE_ENABLE_BIT_POS];
            next_r.ack_sequence_enable = r.wdata[ACK_SEQUENCE_ENABLE_POS] && !r.wdata[RECEIVE_ENABLE_BIT_POS];
            next_r.stop_enable = r.wdata[PEN_POS] && !r.wdata[RECEIVE_ENABLE_BIT_POS]
                         && !r.wdata[ACK_SEQUENCE_ENABLE_POS];
          end
        end
        STATUS_OFFSET: if (r.wstb) begin
          // Write one to clear; a same-cycle hardware set wins below
          next_r.ov = r.ov && !r.wdata[OV_POS];
          next_r.write_collision_flag = r.write_collision_flag && !r.wdata[WRITE_COLLISION_FLAG_POS];
          next_r.sif = r.sif && !r.wdata[SIF_POS];
          next_r.bcl = r.bcl && !r.wdata[BCL_POS];
        end
        BUFFER_OFFSET: if (r.wstb) begin
          if (r.state != IDLE) begin
            next_r.write_collision_flag = 1'b1;
          end else begin
            next_r.buffer = r.wdata[7:0];
          end
        end
        BAUD_OFFSET: if (r.wstb) begin
          next_r.reload = r.wdata[7:0];
        end
        default: next_r.bresp = RESP_SLVERR;
      endcase
    end
    if (r.bvalid && bready) begin
      next_r.bvalid = 1'b0;
      next_r.awready = 1'b1;
      next_r.wready = 1'b1;
    end
    if (arvalid && r.arready) begin
      next_r.arready = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = RESP_OKAY;
      next_r.rdata = 32'h0000_0000;
      case (araddr)
        CTRL_OFFSET: next_r.rdata[7:0] = ctrl_v;
        STATUS_OFFSET: next_r.rdata[7:0] = stat_v;
        BUFFER_OFFSET: begin
          next_r.rdata[7:0] = r.buffer;
          next_r.bf = 1'b0;
        end
        BAUD_OFFSET: next_r.rdata[7:0] = r.reload;
        default: next_r.rresp = RESP_SLVERR;
      endcase
    end
    if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end
    // foreign stop raises interrupt
    // After the status write so that a same-cycle clear loses
    if (scl_s && !r.sda_prev && sda_s && r.sdet && r.ie && r.state == IDLE) begin
      next_r.sif = 1'b1;
    end

    // ========================================================
    // Sequencer; lines are only released or pulled low
    case (r.state)
      IDLE: begin
        if (r.receive_enable_bit) begin
          next_r.state = RX_CLOCK;
          next_r.run = 1'b1;
          next_r.cnt = r.reload;
          next_r.bits = 3'h0;
          next_r.sda_rel = 1'b1;
        end else if (r.ack_sequence_enable) begin
          next_r.state = ACK_LOW;
          next_r.scl_rel = 1'b0;
          next_r.sda_rel = r.ack_data_bit;
          next_r.run = 1'b1;
          next_r.cnt = r.reload;
        end else if (r.stop_enable) begin
          next_r.state = STOP_SDA;
          next_r.sda_rel = 1'b0;
        end
      end
      RX_CLOCK: begin
        if (r.scl_rel && !scl_s) begin
          // Slave stretching the clock reloads the count
          next_r.cnt = r.reload;
        end else if (tick) begin
          // toggle clock, sample data at the falling edge
          next_r.scl_rel = !r.scl_rel;
          if (r.scl_rel) begin
            next_r.sreg = {r.sreg[6:0], sda_s};
            next_r.bits = r.bits + 3'h1;
            if (r.bits == LAST_BIT) begin
              next_r.receive_enable_bit = 1'b0;
              next_r.run = 1'b0;
              next_r.buffer = {r.sreg[6:0], sda_s};
              next_r.bf = 1'b1;
              next_r.sif = 1'b1;
              next_r.state = IDLE;
              if (r.bf) begin
                next_r.ov = 1'b1;
              end
            end
          end
        end
      end
      ACK_LOW: begin
        if (tick) begin
          next_r.scl_rel = 1'b1;
          next_r.run = 1'b0;
          next_r.state = ACK_WAIT;
        end
      end
      ACK_WAIT: begin
        // count starts once the clock is seen high
        if (scl_s) begin
          next_r.run = 1'b1;
          next_r.cnt = r.reload;
          next_r.state = ACK_HIGH;
        end
      end
      ACK_HIGH: begin
        // released data pulled low by another master
        if (r.sda_rel && !sda_s) begin
          collide = 1'b1;
        end else if (tick) begin
          next_r.scl_rel = 1'b0;
          next_r.ack_sequence_enable = 1'b0;
          next_r.run = 1'b0;
          next_r.state = IDLE;
        end
      end
      STOP_SDA: begin
        if (!sda_s) begin
          next_r.run = 1'b1;
          next_r.cnt = r.reload;
          next_r.state = STOP_CNT;
        end
      end
      STOP_CNT: begin
        if (tick) begin
          next_r.scl_rel = 1'b1;
          next_r.state = STOP_SCLH;
        end
      end
      STOP_SCLH: begin
        if (!scl_s) begin
          next_r.cnt = r.reload;
        end else if (tick) begin
          next_r.sda_rel = 1'b1;
          next_r.state = STOP_SDAH;
        end
      end
      STOP_SDAH: begin
        if (sda_s && scl_s) begin
          next_r.pdet = 1'b1;
          next_r.sdet = 1'b0;
          next_r.cnt = r.reload;
          next_r.state = STOP_END;
        end else if (!scl_s || tick) begin
          // clock lost, or data still held low
          collide = 1'b1;
        end
      end
      STOP_END: begin
        if (tick) begin
          next_r.stop_enable = 1'b0;
          next_r.sif = 1'b1;
          next_r.run = 1'b0;
          next_r.state = IDLE;
        end
      end
      default: next_r.state = IDLE;
    endcase
    if (collide) begin
      next_r.bcl = 1'b1;
      next_r.state = IDLE;
      next_r.run = 1'b0;
      next_r.scl_rel = 1'b1;
      next_r.sda_rel = 1'b1;
      next_r.receive_enable_bit = 1'b0;
      next_r.ack_sequence_enable = 1'b0;
      next_r.stop_enable = 1'b0;
    end
    // disabled module is idle and forgets bus state
    if (!r.en) begin
      next_r.state = IDLE;
      next_r.run = 1'b0;
      next_r.scl_rel = 1'b1;
      next_r.sda_rel = 1'b1;
      next_r.receive_enable_bit = 1'b0;
      next_r.ack_sequence_enable = 1'b0;
      next_r.stop_enable = 1'b0;
      next_r.sdet = 1'b0;
      next_r.pdet = 1'b0;
    end
    next_r.irq = next_r.sif && next_r.ie;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= RESET_REGS;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Outputs
  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = r.scl_rel;
  assign sda_oe_n = r.sda_rel;
  assign irq = r.irq;

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rx_ignore_a: assert property (wr_fire && r.awaddr == CTRL_OFFSET && r.wstb
    && r.state != IDLE && !r.receive_enable_bit |=> !r.receive_enable_bit) else $error("rx request taken while busy");
  rx_done_a: assert property (r.state == RX_CLOCK && tick && r.scl_rel
    && !(r.scl_rel && !scl_s) && r.bits == LAST_BIT && r.en
    |=> r.bf && r.sif && !r.receive_enable_bit && r.state == IDLE ##1 !scl_oe_n)
    else $error("byte completion wrong");
  overflow_a: assert property (r.state == RX_CLOCK && tick && r.scl_rel
    && scl_s && r.bits == LAST_BIT && r.bf && r.en |=> r.ov)
    else $error("overflow not flagged");
  write_collision_flag_set_a: assert property (wr_fire && r.awaddr == BUFFER_OFFSET
    && r.wstb && r.state != IDLE
    && !(r.state == RX_CLOCK && tick && r.scl_rel && r.bits == LAST_BIT)
    |=> r.write_collision_flag && $stable(r.buffer))
    else $error("busy buffer write not refused");
  ack_drive_a: assert property (r.state == IDLE ##1 r.state == ACK_LOW
    |-> !scl_oe_n && sda_oe_n == r.ack_data_bit) else $error("ack drive wrong");
  stop_sda_a: assert property (r.state == STOP_CNT |-> !r.sda_rel)
    else $error("stop lost data low");
  stop_end_a: assert property (r.state == STOP_END && tick && r.en
    |=> !r.stop_enable && r.sif ##1 irq == r.ie) else $error("stop end wrong");
  bcl_idle_a: assert property (collide && r.en |=> r.bcl
    && r.state == IDLE ##1 scl_oe_n && sda_oe_n) else $error("collision not handled");
  disable_clr_a: assert property (!r.en |=> !r.sdet && !r.pdet
    && r.state == IDLE) else $error("disable left state");

  rx_byte_c: cover property (r.state == RX_CLOCK ##1 r.state == IDLE && r.bf);
  ack_seq_c: cover property (r.state == ACK_HIGH ##1 r.state == IDLE);
  stop_seq_c: cover property (r.state == STOP_END ##1 r.state == IDLE);
  collide_c: cover property (collide);
endmodule

`default_nettype wire

// ===== i2c_slave_model.sv
// Behavioural two-wire slave that sends one byte per activation, MSB first.
// Assumes resolved wire levels from the bench and the block's clock for stretching.
`timescale 1ns/1ps
`default_nettype none

module i2c_slave_model (
  // Clock
  input wire logic aclk,
  // Resolved clock line
  input wire logic scl,
  // Bench control
  input wire logic active,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] stretch,
  // Open-drain pulls
  output logic sda_low,
  output logic scl_low
);
  int idx;
  int since;
  logic scl_seen;

  initial begin
    idx = 0;
    since = 255;
    scl_seen = 1'b1;
  end

  // ==========
  // Bit shifting
  // Count restarts each time the bench withdraws the slave
  always @(negedge scl or negedge active) begin
    if (!active) idx = 0;
    else idx = idx + 1;
  end
  // pull only, new bit after each fall
  assign sda_low = active && (idx < 8) && !tx_byte[3'(7 - idx)];

  // ==========
  // Clock stretching
  always @(posedge aclk) begin
    scl_seen <= scl;
    if (scl_seen && !scl) since <= 0;
    else if (since < 255) since <= since + 1;
  end
  // slow slave holds the clock low, never drives it high
  assign scl_low = active && (since < int'(stretch));
endmodule
`default_nettype wire

// ===== i2c_master_rx_ack_stop_bench.sv
// Self-checking bench for the receive, acknowledge and stop sequencer.
// Assumes the slave model beside it and pull-ups on both resolved lines.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_rx_ack_stop_bench
  import i2c_rx_pkg::*;
;
  localparam logic [31:0] M_EI = (32'h1 << EN_POS) | (32'h1 << IE_POS);
  localparam logic [31:0] M_RX = 32'h1 << RECEIVE_ENABLE_BIT_POS;
  localparam logic [31:0] M_AK = 32'h1 << ACK_SEQUENCE_ENABLE_POS;
  localparam logic [31:0] M_AD = 32'h1 << ACK_DATA_BIT_POS;
  localparam logic [31:0] M_SP = 32'h1 << PEN_POS;
  localparam logic [31:0] M_FULL = 32'h1 << BF_POS;
  localparam logic [31:0] M_OV = 32'h1 << OV_POS;
  localparam logic [31:0] M_WC = 32'h1 << WRITE_COLLISION_FLAG_POS;
  localparam logic [31:0] M_IF = 32'h1 << SIF_POS;
  localparam logic [31:0] M_BC = 32'h1 << BCL_POS;
  localparam logic [31:0] M_PD = 32'h1 << PDET_POS;
  localparam logic [31:0] M_SD = 32'h1 << SDET_POS;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq, scl_oe_n, sda_oe_n;
  logic [1:0] bresp, rresp, last_resp;
  logic [31:0] rdata;
  logic scl, sda, sda_low, scl_low;
  logic scl_drv, sda_drv;
  logic slave_on = 1'b0;
  logic coll_arm = 1'b0;
  logic foreign_low = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] stretch = 8'h00;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int scl_rises = 0;
  int stop_cnt = 0;

  always #4 aclk = ~aclk;
  assign scl = (scl_oe_n || scl_drv) && !scl_low;
  assign sda = (sda_oe_n || sda_drv) && !sda_low && !foreign_low;
  always @(posedge scl) scl_rises++;
  always @(posedge sda) if (scl === 1'b1) stop_cnt++;

  i2c_master_rx_ack_stop i_i2c_master_rx_ack_stop (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hF), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .scl_i(scl), .scl_o(scl_drv), .scl_oe_n, .sda_i(sda), .sda_o(sda_drv),
    .sda_oe_n, .irq
  );
  i2c_slave_model i_i2c_slave_model (
    .aclk, .scl, .active(slave_on), .tx_byte, .stretch, .sda_low, .scl_low
  );

  // ==========
  // Timeout and another master on the data line
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (coll_arm && scl) foreign_low <= 1'b1;
    if (cycles == 30000) begin
      bad_count++;
      summarize();
    end
  end

  // ==========
  // Shared tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    last_resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    axi_rd(a, d);
    chk(d & m, e);
  endtask
  // Polls control until the self-clearing bits drop
  task automatic wclr(input logic [31:0] m);
    logic [31:0] d;
    do begin
      axi_rd(CTRL_OFFSET, d);
    end while ((d & m) !== 32'h0);
  endtask
  task automatic do_rx(input logic [7:0] b, input logic [7:0] s, input logic mid);
    tx_byte <= b;
    stretch <= s;
    slave_on <= 1'b1;
    axi_wr(CTRL_OFFSET, M_EI | M_RX);
    if (mid) begin
      axi_wr(CTRL_OFFSET, M_EI | M_RX | M_AK); // command while busy
      axi_wr(BUFFER_OFFSET, 32'h3C); // write while shifting
      rc(STATUS_OFFSET, 32'h1 << BUSY_POS, 32'h1 << BUSY_POS); // busy while shifting
    end
    wclr(M_RX); // receive bit clears
    slave_on <= 1'b0;
    @(posedge aclk);
  endtask

  // ==========
  // Scenarios
  task automatic t_reset();
    logic [31:0] d;
    rc(CTRL_OFFSET, 32'hFF, 32'h0); // disabled
    rc(STATUS_OFFSET, 32'hFF, 32'h0); // detect bits clear
    rc(BAUD_OFFSET, 32'hFF, 32'(BAUD_RESET)); // reload value
    axi_rd(4'h2, d);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    chk(d, 32'h0);
    axi_wr(4'h2, 32'h0);
    chk(32'(last_resp), 32'(RESP_SLVERR));
    chk(32'({scl_oe_n, sda_oe_n}), 32'h3); // both released
    axi_wr(BUFFER_OFFSET, 32'hA1); // address byte with read bit
    rc(BUFFER_OFFSET, 32'hFF, 32'hA1); // idle write stored
    // Reload 6 gives a bit time near 125 ns
    axi_wr(BAUD_OFFSET, 32'h06);
    rc(BAUD_OFFSET, 32'hFF, 32'h06); // reload value
    axi_wr(CTRL_OFFSET, M_EI);
    chk(32'(last_resp), 32'(RESP_OKAY));
    $display("test reset done");
  endtask
  task automatic t_ack(input logic n);
    int r0;
    r0 = scl_rises;
    axi_wr(CTRL_OFFSET, M_EI | M_AK | (n ? M_AD : 32'h0)); // data bit then start
    repeat (2) @(posedge aclk);
    chk(32'({scl_oe_n, sda_oe_n}), {31'h0, n}); // clock low, bit driven
    wclr(M_AK); // sequence ends
    chk(32'(scl_rises - r0), 32'h1); // one clock pulse
    chk(32'(scl_oe_n), 32'h0); // clock pulled low
    $display("test ack %0d done", n);
  endtask
  task automatic t_rx1();
    do_rx(8'hA5, 8'h00, 1'b1);
    chk(32'(scl_oe_n), 32'h0); // clock held low
    chk(32'(irq), 32'h1); // interrupt flag
    rc(CTRL_OFFSET, M_RX | M_AK, 32'h0); // command dropped
    rc(STATUS_OFFSET, 32'hFF, M_FULL | M_IF | M_WC); // flags
    rc(BUFFER_OFFSET, 32'hFF, 32'hA5); // byte kept
    rc(STATUS_OFFSET, M_FULL, 32'h0); // read clears full
    axi_wr(STATUS_OFFSET, 32'h1E);
    $display("test rx1 done");
  endtask
  task automatic t_rx_more();
    logic [31:0] d;
    do_rx(8'h5A, 8'd20, 1'b0);
    rc(BUFFER_OFFSET, 32'hFF, 32'h5A); // slow slave byte
    do_rx(8'hC3, 8'h00, 1'b0);
    rc(STATUS_OFFSET, M_OV | M_FULL, M_FULL); // no overflow yet
    do_rx(8'h3C, 8'h00, 1'b0);
    rc(STATUS_OFFSET, M_OV | M_FULL, M_OV | M_FULL); // overflow
    axi_rd(BUFFER_OFFSET, d);
    axi_wr(STATUS_OFFSET, 32'h1E);
    $display("test rx more done");
  endtask
  task automatic t_stop();
    int s0;
    s0 = stop_cnt;
    axi_wr(CTRL_OFFSET, M_EI | M_SP);
    axi_wr(BUFFER_OFFSET, 32'h77); // write during stop
    wclr(M_SP); // stop completes
    rc(STATUS_OFFSET, M_PD | M_IF | M_WC, M_PD | M_IF | M_WC); // flags
    chk(32'(stop_cnt - s0), 32'h1); // one stop on wire
    chk(32'({scl_oe_n, sda_oe_n}), 32'h3); // lines released
    axi_wr(CTRL_OFFSET, 32'h0);
    rc(STATUS_OFFSET, M_PD | M_SD, 32'h0); // cleared on disable
    axi_wr(CTRL_OFFSET, M_EI);
    axi_wr(STATUS_OFFSET, 32'h1E);
    $display("test stop done");
  endtask
  task automatic t_coll();
    axi_wr(CTRL_OFFSET, M_EI | M_AK | M_AD);
    repeat (2) @(posedge aclk);
    coll_arm <= 1'b1;
    wclr(M_AK); // sequence abandoned
    rc(STATUS_OFFSET, M_BC | M_SD, M_BC | M_SD); // collision and start seen
    chk(32'({scl_oe_n, sda_oe_n}), 32'h3); // lines released
    axi_wr(STATUS_OFFSET, 32'h1E);
    coll_arm <= 1'b0;
    @(posedge aclk);
    foreign_low <= 1'b0;
    // Synchroniser plus one cycle to act
    repeat (6) @(posedge aclk);
    rc(STATUS_OFFSET, M_IF | M_PD, M_IF | M_PD); // foreign stop
    chk(32'(irq), 32'h1); // interrupt raised
    $display("test collision done");
  endtask
  task automatic t_abort();
    rc(STATUS_OFFSET, M_PD, M_PD); // bus free after stop
    axi_wr(CTRL_OFFSET, M_EI | M_RX);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk(32'({scl_oe_n, sda_oe_n}), 32'h3); // transfer dropped
    rc(CTRL_OFFSET, 32'hFF, 32'h0); // disabled
    rc(STATUS_OFFSET, M_PD | M_SD, 32'h0); // detect bits clear
    $display("test abort done");
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_ack(1'b1);
    t_rx1();
    t_ack(1'b0);
    t_rx_more();
    t_stop();
    t_coll();
    t_abort();
    summarize();
  end
endmodule
`default_nettype wire
